// file: stxr_pkg.sv
/*
 * shared constants and carrier types for the serial transmit/receive control block.
 * assumes a 125 MHz bus clock and an APB master with 32-bit data.
 */
package stxr_pkg;
	// -------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00; // serial_control_one/two/three merged
	localparam logic [7:0] ADDR_STAT = 8'h04; // serial_status_one/two merged
	localparam logic [7:0] ADDR_DATA = 8'h08; // serial_data_register
	localparam logic [7:0] ADDR_BAUD = 8'h0C; // bit period in clocks
	localparam logic [7:0] ADDR_IRQS = 8'h10; // sticky event status
	localparam logic [7:0] ADDR_IRQM = 8'h14; // event mask
	// -------------------------------------------------------------
	// control bit positions
	// -------------------------------------------------------------
	localparam int C_UNIT = 0;  // serial_unit_on
	localparam int C_TE = 1;    // transmit_enable
	localparam int C_RE = 2;    // rx_enable
	localparam int C_STBY = 3;  // rx_standby_bit
	localparam int C_BRK = 4;   // break_send_bit
	localparam int C_NINE = 5;  // word length: nine data bits
	localparam int C_WAKE = 6;  // standby exit: 1 = address mark
	localparam int C_TX_DONE_IRQ_ON = 7;  // tx_done_irq_on
	localparam int C_RFIE = 8;  // rx_full_irq_on
	localparam int C_LINE_QUIET_IRQ_ON = 9;  // line_quiet_irq_on
	localparam int C_T8 = 10;   // ninth transmit bit
	localparam int C_W = 11;
	// -------------------------------------------------------------
	// status bit positions
	// -------------------------------------------------------------
	localparam int S_TDE = 0;   // tx_data_empty_flag
	localparam int S_TC = 1;    // tx_done_flag
	localparam int S_RF = 2;    // rx_full_flag
	localparam int S_IDLE = 3;  // receiver idle
	localparam int S_FE = 4;    // framing_error_flag
	localparam int S_BKF = 5;   // break_flag
	localparam int S_R8 = 6;    // ninth_rx_bit
	localparam int S_RPF = 7;   // rx_active_flag
	localparam int S_OR = 8;    // overrun
	// -------------------------------------------------------------
	// interrupt event bits
	// -------------------------------------------------------------
	localparam int E_TC = 0;
	localparam int E_RF = 1;
	localparam int E_IDLE = 2;
	localparam int E_W = 3;
	localparam logic [15:0] BAUD_RST = 16'h0010; // clocks per bit after reset
	localparam logic [3:0] SMP_MID = 4'h8;       // sample point in 16ths of a bit
	localparam logic [3:0] IDLE_EIGHT = 4'hA;    // idle ones, eight data bits
	localparam logic [3:0] IDLE_NINE = 4'hB;     // idle ones, nine data bits
	// apb request bundle
	typedef struct packed {
		logic sel;
		logic en;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} stxr_apb_req_t;
	typedef enum {TX_IDLE, TX_PRE, TX_DATA, TX_BRK, TX_MARK} stxr_tx_st_t;
	typedef enum {RX_WAIT, RX_BITS} stxr_rx_st_t;
endpackage

// file: stxr_top.sv
/*
 * serial transmit/receive control unit with apb register access.
 * assumes an apb master on clk and an asynchronous serial line on rxdPin.
 */
//
// Behaviour
// R1: break end sends at least one mark bit
// R2: all-zero frame with zero stop is break
// R3: break sets flags, clears data and ninth
// R4: idle char is all ones, word length
// R5: each transmission starts with preamble (code sends one only after te is set or an idle is queued)
// R6: te clear idles after current character
// R7: te toggle queues one idle character
// R8: software toggles te before stop bit
// R9: te/re writes ignored while unit off
// R10: re enables receiver, flags untouched
// R11: standby masks rx irqs, exits on wake
// R12: held break sends breaks back to back
// R13: early break toggle replaces preamble
// R14: tde clears by status read, data write
// R15: tc set when nothing sends, auto clear
// R16: rx full sets on transfer, read clears
// R17: idle flag after ten/eleven ones
// R18: valid character arms idle detection
// R19: word length selects eight or nine bits
module stxr_top import stxr_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxdPin,
	output logic txOutputPin,
	output logic irq
);
	// -------------------------------------------------------------
	// bus decode
	// -------------------------------------------------------------
	stxr_apb_req_t req;
	assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
	// side effects only at the edge that completes the transfer (pready high)
	wire acc = req.sel & req.en & pready & clkEn;
	wire wrEv = acc & req.wr;
	wire rdEv = acc & ~req.wr;
	wire hitCtrl = req.addr == ADDR_CTRL;
	wire hitStat = req.addr == ADDR_STAT;
	wire hitData = req.addr == ADDR_DATA;
	wire hitBaud = req.addr == ADDR_BAUD;
	wire hitIrqs = req.addr == ADDR_IRQS;
	wire hitIrqm = req.addr == ADDR_IRQM;
	wire mapped = hitCtrl | hitStat | hitData | hitBaud | hitIrqs | hitIrqm;

	logic [C_W-1:0] ctrl_r;       // control bits
	logic [15:0] baud_r;          // clocks per bit
	logic [8:0] txHold_r;         // data waiting for the shifter
	logic [7:0] rxData_r;         // serial_data_register receive side
	logic tde_r, tc_r, rf_r, idle_r, fe_r, bkf_r, r8_r, or_r;
	logic tdeSeen_r, rxSeen_r;    // status read saw flag set
	logic [E_W-1:0] irqs_r, irqm_r;
	logic idleQ_r;                // queued idle character
	logic idleArm_r;              // a valid character arms idle detection

	// -------------------------------------------------------------
	// control writes
	// -------------------------------------------------------------
	wire ctrlWr = wrEv & hitCtrl;
	logic [C_W-1:0] ctrlW;
	always_comb begin
		ctrlW = req.wdata[C_W-1:0];
		if (!ctrl_r[C_UNIT]) begin
			ctrlW[C_TE] = ctrl_r[C_TE]; // [R9]
			ctrlW[C_RE] = ctrl_r[C_RE]; // [R9]
		end
	end
	wire teOff = ctrlWr & ctrl_r[C_TE] & ~ctrlW[C_TE];
	wire teOn = ctrlWr & ~ctrl_r[C_TE] & ctrlW[C_TE];
	wire reOn = ctrlWr & ~ctrl_r[C_RE] & ctrlW[C_RE];
	logic wakeEv; // standby exit event from the receiver

	// -------------------------------------------------------------
	// transmitter
	// -------------------------------------------------------------
	stxr_tx_st_t txSt_r;
	logic [15:0] txCnt_r;
	logic [3:0] txBit_r;
	logic [10:0] txSh_r;
	wire txTick = txCnt_r == 16'h0000;
	wire [3:0] frameBits = ctrl_r[C_NINE] ? IDLE_NINE : IDLE_EIGHT; // [R19]
	wire txLast = txTick & (txBit_r == frameBits - 4'h1);
	wire txBusy = txSt_r != TX_IDLE;
	logic preNeed_r; // enabling the transmitter owes a preamble
	// tc may drop up to a bit early: queueing sets it clear at once
	wire txQueued = ~tde_r | preNeed_r | ctrl_r[C_BRK] | idleQ_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txSt_r <= TX_IDLE;
			txCnt_r <= 16'h0000;
			txBit_r <= 4'h0;
			txSh_r <= 11'h7FF;
			preNeed_r <= 1'b0;
		end else if (clkEn) begin
			txCnt_r <= txTick ? baud_r - 16'h0001 : txCnt_r - 16'h0001;
			if (teOn) preNeed_r <= 1'b1; // [R5]
			unique case (txSt_r)
				TX_IDLE: begin
					txBit_r <= 4'h0;
					if (ctrl_r[C_TE] & txTick) begin
						if (ctrl_r[C_BRK]) begin
							txSt_r <= TX_BRK;  // [R13] break wins over a pending preamble
							txSh_r <= 11'h000;
							preNeed_r <= 1'b0;
						end else if (preNeed_r | idleQ_r) begin
							txSt_r <= TX_PRE;  // [R5] [R7]
							txSh_r <= 11'h7FF; // [R4]
							preNeed_r <= 1'b0;
						end else if (!tde_r) begin
							txSt_r <= TX_DATA;
							txSh_r <= ctrl_r[C_NINE] ? {1'b1, txHold_r, 1'b0}
								: {2'b11, txHold_r[7:0], 1'b0};
						end
					end
				end
				TX_PRE, TX_DATA: if (txTick) begin
					txSh_r <= {1'b1, txSh_r[10:1]};
					txBit_r <= txBit_r + 4'h1;
					if (txLast) txSt_r <= TX_IDLE; // [R6] te only checked between frames
				end
				TX_BRK: if (txTick) begin
					txBit_r <= txBit_r + 4'h1;
					if (txLast) begin
						txBit_r <= 4'h0;
						// held break repeats, else one mark bit follows
						if (!ctrl_r[C_BRK]) begin
							txSt_r <= TX_MARK; // [R12] [R1]
							txSh_r <= 11'h7FF; // line rests at mark after the break
						end
					end
				end
				TX_MARK: if (txTick) txSt_r <= TX_IDLE; // [R1]
				default: txSt_r <= TX_IDLE;
			endcase
		end
	end
	wire txLoad = clkEn & (txSt_r == TX_IDLE) & ctrl_r[C_TE] & txTick & ~ctrl_r[C_BRK]
		& ~preNeed_r & ~idleQ_r & ~tde_r;
	wire preStart = clkEn & (txSt_r == TX_IDLE) & ctrl_r[C_TE] & txTick & ~ctrl_r[C_BRK]
		& (preNeed_r | idleQ_r);

	// -------------------------------------------------------------
	// receiver: three-stage synchroniser, agreement of last two
	// -------------------------------------------------------------
	logic [2:0] rxSync_r;
	logic rxLvl_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxSync_r <= 3'b111;
			rxLvl_r <= 1'b1;
		end else if (clkEn) begin
			rxSync_r <= {rxSync_r[1:0], rxdPin};
			if (rxSync_r[2] == rxSync_r[1]) rxLvl_r <= rxSync_r[2];
		end
	end

	stxr_rx_st_t rxSt_r;
	logic [15:0] rxCnt_r;
	logic [3:0] rxBit_r, onesCnt_r;
	logic [9:0] rxSh_r;
	wire rxOn = ctrl_r[C_RE]; // [R10]
	wire rxSample = rxCnt_r == 16'h0000;
	wire [15:0] halfBit = baud_r >> 1;
	// done at the stop-bit sample: data bits plus one stop
	wire rxDone = rxSample & (rxSt_r == RX_BITS) & (rxBit_r == frameBits - 4'h2);
	// frame complete: data bits in rxSh_r[9:2] (nine bits: rxSh_r[9:1]) and stop bit is the current level
	wire [8:0] rxWord = ctrl_r[C_NINE] ? rxSh_r[9:1] : {1'b0, rxSh_r[9:2]};
	wire rxBreak = rxDone & (rxWord == 9'h000) & ~rxLvl_r; // [R2]
	wire rxFrameErr = rxDone & ~rxLvl_r;
	wire idleHit = rxSample & rxOn & (rxSt_r == RX_WAIT) & rxLvl_r
		& (onesCnt_r == frameBits - 4'h1) & idleArm_r; // [R17]
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxSt_r <= RX_WAIT;
			rxCnt_r <= 16'h0000;
			rxBit_r <= 4'h0;
			rxSh_r <= 10'h000;
			onesCnt_r <= 4'h0;
		end else if (clkEn) begin
			rxCnt_r <= rxSample ? baud_r - 16'h0001 : rxCnt_r - 16'h0001;
			if (!rxOn) begin
				rxSt_r <= RX_WAIT;
				onesCnt_r <= 4'h0;
			end else unique case (rxSt_r)
				RX_WAIT: begin
					if (!rxLvl_r) begin
						rxSt_r <= RX_BITS; // start edge: sample mid-bit from here
						rxCnt_r <= baud_r + halfBit;
						rxBit_r <= 4'h0;
						onesCnt_r <= 4'h0;
					end else if (rxSample && onesCnt_r != IDLE_NINE) begin
						onesCnt_r <= onesCnt_r + 4'h1;
					end
				end
				RX_BITS: if (rxSample) begin
					rxSh_r <= {rxLvl_r, rxSh_r[9:1]};
					rxBit_r <= rxBit_r + 4'h1;
					if (rxDone) rxSt_r <= RX_WAIT;
				end
				default: rxSt_r <= RX_WAIT;
			endcase
		end
	end
	assign wakeEv = ctrl_r[C_WAKE] ? (rxDone & rxWord[7]) : idleHit; // [R11]

	// -------------------------------------------------------------
	// flags and clearing sequences
	// -------------------------------------------------------------
	wire statRd = rdEv & hitStat;
	wire dataRd = rdEv & hitData;
	wire dataWr = wrEv & hitData;
	wire rxClr = dataRd & rxSeen_r; // [R16] [R17]
	wire tdeClr = dataWr & tdeSeen_r; // [R14]
	wire rxLoad = rxDone & ~ctrl_r[C_STBY];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= '0;          // [R9] [R10] [R11] [R12]
			baud_r <= BAUD_RST;
			txHold_r <= 9'h000;
			rxData_r <= 8'h00;
			tde_r <= 1'b1;         // [R14]
			tc_r <= 1'b1;          // [R15]
			{rf_r, idle_r, fe_r, bkf_r, r8_r, or_r} <= '0;
			{tdeSeen_r, rxSeen_r, idleQ_r, idleArm_r} <= '0;
			irqs_r <= '0;
			irqm_r <= '0;
		end else if (clkEn) begin
			if (ctrlWr) ctrl_r <= ctrlW;
			if (wakeEv & ctrl_r[C_STBY]) ctrl_r[C_STBY] <= 1'b0; // [R11]
			if (wrEv & hitBaud) baud_r <= req.wdata[15:0];
			if (wrEv & hitIrqm) irqm_r <= req.wdata[E_W-1:0];
			// queued idle: te cleared then set while busy
			if (teOn & txBusy) idleQ_r <= 1'b1; // [R7] [R8]
			else if (preStart) idleQ_r <= 1'b0;
			if (teOff & ~txBusy) idleQ_r <= 1'b0;
			// transmit-empty: set on shifter load, set wins
			if (statRd) tdeSeen_r <= tde_r;
			if (tdeClr) begin
				txHold_r <= {ctrl_r[C_T8], req.wdata[7:0]};
				tde_r <= 1'b0; // [R14]
				tdeSeen_r <= 1'b0;
			end
			if (txLoad) tde_r <= 1'b1;
			tc_r <= tde_r & ~txBusy & ~txQueued; // [R15]
			// receive flags: clear by status read then data read, set wins
			if (statRd) rxSeen_r <= rf_r | idle_r;
			if (rxClr) begin
				rf_r <= 1'b0;
				idle_r <= 1'b0;
				fe_r <= 1'b0;
				bkf_r <= 1'b0;
				or_r <= 1'b0;
				rxSeen_r <= 1'b0;
				if (idle_r) idleArm_r <= 1'b0; // [R18]
			end
			if (reOn) idleArm_r <= 1'b0; // [R18]
			if (rxLoad) begin
				rf_r <= 1'b1; // [R16]
				or_r <= rf_r & ~rxClr;
				fe_r <= rxFrameErr;
				idleArm_r <= 1'b1; // [R18]
				rxData_r <= rxBreak ? 8'h00 : rxWord[7:0]; // [R3]
				r8_r <= rxBreak ? 1'b0 : rxWord[8]; // [R3]
				if (rxBreak) bkf_r <= 1'b1; // [R3]
			end
			if (idleHit) begin
				idle_r <= 1'b1; // [R17]
				idleArm_r <= 1'b0;
			end
			// sticky interrupt status, write one to clear, set wins
			irqs_r <= (irqs_r & ~({E_W{wrEv & hitIrqs}} & req.wdata[E_W-1:0]))
				| {idleHit & ctrl_r[C_LINE_QUIET_IRQ_ON] & ~ctrl_r[C_STBY],
				rxLoad & ctrl_r[C_RFIE], // standby drops rx interrupts [R11]
				txLoad & ctrl_r[C_TX_DONE_IRQ_ON] & 1'b0 | (~tc_r & tde_r & ~txBusy & ~txQueued
				& ctrl_r[C_TX_DONE_IRQ_ON])}; // [R15]
		end
	end

	// -------------------------------------------------------------
	// read mux and registered outputs
	// -------------------------------------------------------------
	wire [31:0] statWord = {23'h0, or_r, rxSt_r == RX_BITS, r8_r, bkf_r, fe_r, idle_r,
		rf_r, tc_r, tde_r};
	wire [31:0] rdMux = hitCtrl ? {21'h0, ctrl_r} : hitStat ? statWord
		: hitData ? {24'h0, rxData_r} : hitBaud ? {16'h0, baud_r}
		: hitIrqs ? {29'h0, irqs_r} : hitIrqm ? {29'h0, irqm_r} : 32'h0000_0000;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			txOutputPin <= 1'b1;
			irq <= 1'b0;
		end else if (clkEn) begin
			// one wait state: answer in the cycle after the access phase opens
			pready <= req.sel & req.en & ~pready;
			pslverr <= req.sel & req.en & ~pready & ~mapped;
			prdata <= rdMux;
			txOutputPin <= (txSt_r == TX_BRK) ? 1'b0
				: (txSt_r == TX_MARK) ? 1'b1 : txSh_r[0]; // [R12] [R1]
			irq <= |(irqs_r & irqm_r);
		end
	end
endmodule // stxr_top

// file: stxr_top_monitor.sv
/*
 * concurrent checks on the ports of the serial control unit.
 * assumes one clock domain, the reset bit period and an apb master.
 */
module stxr_top_monitor import stxr_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxdPin,
	input wire logic txOutputPin,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// shared clocking and sequences
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// access phase seen, answer not yet given
	sequence sAccess;
		psel && penable && !pready && clkEn;
	endsequence
	// status read answered while the line carries a space
	sequence sStatLow;
		pready && !pwrite && paddr == ADDR_STAT && !txOutputPin;
	endsequence
	a_ready_after_access: assert property (sAccess |=> pready)
		else $error("pready late");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready stretched");
	a_ready_needs_req: assert property (pready |-> psel && penable)
		else $error("pready without access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped not refused");
	a_ok_mapped: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped refused");
	a_tx_reset_idle: assert property ($rose(rst_b) |-> txOutputPin)
		else $error("line not idle after reset");
	a_tc_while_low: assert property (sStatLow |-> !prdata[S_TC])
		else $error("done flag while sending");
	a_irq_mask_off: assert property (pready && pwrite && paddr == ADDR_IRQM && pwdata[2:0] == 3'h0 |-> ##2 !irq)
		else $error("masked irq high");
	a_mark_bit_hold: assert property ($rose(txOutputPin) |-> txOutputPin[*8])
		else $error("mark bit too short");
endmodule // stxr_top_monitor

bind stxr_top stxr_top_monitor u_mon (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxdPin(rxdPin), .txOutputPin(txOutputPin), .irq(irq));

// file: stxr_peer.sv
/*
 * remote serial node: sends frames on the receive line, samples the transmit line.
 * assumes BIT clocks per bit, matching the unit's reset bit period.
 */
module stxr_peer #(parameter int BIT = 16) (
	input wire logic clk,
	output logic rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 1ps;
	// line rests at mark, as a pulled-up idle line would
	initial rxd = 1'b1;
	// one frame, lsb first; a zero stop bit makes a break when data is zero
	task automatic sendChar(input logic [7:0] d, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask
	// waits for a start bit, returns data plus stop bit and the wait length
	task automatic getChar(output logic [8:0] d, output int n);
		n = 0;
		while (txd !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge clk);
			d[i] = txd;
		end
	endtask
endmodule // stxr_peer

// file: tb.sv
/*
 * self-checking bench for the serial control unit over apb.
 * assumes the reset bit period of 16 clocks and the peer model.
 */
module tb import stxr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, st;
	logic pready, pslverr, rxdPin, txOutputPin, irq, lastErr;
	logic [8:0] ch;
	int w;
	int nFail = 0;
	int totalChecks = 0;
	localparam logic [31:0] CTL = 32'h0000_0387; // unit, te, re and all irq enables
	always #4 clk = ~clk;
	stxr_top DUT (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxdPin(rxdPin), .txOutputPin(txOutputPin), .irq(irq));
	stxr_peer peer (.clk(clk), .rxd(rxdPin), .txd(txOutputPin));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) nFail++;
		st = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic lineWait(input logic lv);
		int k;
		k = 0;
		while (txOutputPin !== lv && k < 2000) begin
			@(posedge clk);
			k++;
		end
		chk("txLevel", {31'h0, lv}, {31'h0, txOutputPin});
	endtask
	task automatic testDone;
		if (nFail == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(0, ADDR_STAT, 0); chk("statRst", 32'h3, st & 32'h1FF);
		apb(0, ADDR_CTRL, 0); chk("ctrlRst", 32'h0, st & 32'h1F);
		apb(1, ADDR_CTRL, 32'h6);
		apb(0, ADDR_CTRL, 0); chk("teReOff", 32'h0, st & 32'h6);
		apb(0, 8'h18, 0); chk("unmapErr", 32'h1, {31'h0, lastErr});
		chk("unmapData", 32'h0, st);
		apb(1, ADDR_IRQM, 32'h1);
		apb(1, ADDR_CTRL, 32'h1); // unit on first: te/re writes need it
		apb(1, ADDR_CTRL, CTL);
		apb(0, ADDR_CTRL, 0); chk("ctrlOn", CTL, st & 32'h7FF);
		apb(0, ADDR_STAT, 0);
		apb(1, ADDR_DATA, 32'hA5);
		apb(0, ADDR_STAT, 0); chk("tdeBusy", 32'h0, st & 32'h3);
		peer.getChar(ch, w); chk("txChar", 32'h1A5, {23'h0, ch});
		chk("preamble", 32'h1, {31'h0, w >= 120});
		repeat (40) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("txDone", 32'h3, st & 32'h3);
		chk("irqTc", 32'h1, {31'h0, irq});
		apb(1, ADDR_IRQM, 0);
		repeat (3) @(posedge clk);
		chk("irqMask", 32'h0, {31'h0, irq});
		apb(1, ADDR_IRQS, 32'h1);
		apb(0, ADDR_IRQS, 0); chk("irqClr", 32'h0, st & 32'h1);
		// te toggled inside a frame: one idle character follows it
		apb(0, ADDR_STAT, 0);
		apb(1, ADDR_DATA, 32'h5A);
		lineWait(1'b0);
		apb(1, ADDR_CTRL, CTL & ~32'h2); apb(1, ADDR_CTRL, CTL);
		repeat (200) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("idleQueued", 32'h1, st & 32'h3);
		repeat (150) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("idleSent", 32'h3, st & 32'h3);
		// break held for two frame times, then released
		apb(1, ADDR_CTRL, CTL | 32'h10);
		lineWait(1'b0);
		repeat (300) @(posedge clk);
		chk("brkHeld", 32'h0, {31'h0, txOutputPin});
		apb(1, ADDR_CTRL, CTL);
		lineWait(1'b1);
		repeat (12) @(posedge clk);
		chk("brkMark", 32'h1, {31'h0, txOutputPin});
		apb(0, ADDR_STAT, 0); chk("noIdle", 32'h0, st & 32'h8);
		// receive one character, then let the line go quiet
		apb(1, ADDR_IRQM, 32'h6);
		peer.sendChar(8'h3C, 1'b1);
		repeat (20) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("rxFull", 32'h4, st & 32'h3C);
		chk("irqRx", 32'h1, {31'h0, irq});
		apb(0, ADDR_DATA, 0); chk("rxData", 32'h3C, st & 32'hFF);
		apb(0, ADDR_STAT, 0); chk("rxClr", 32'h0, st & 32'h4);
		repeat (200) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("idleSet", 32'h8, st & 32'h8);
		apb(0, ADDR_DATA, 0);
		apb(0, ADDR_STAT, 0); chk("idleClr", 32'h0, st & 32'h8);
		repeat (250) @(posedge clk);
		apb(0, ADDR_STAT, 0); chk("idleRearm", 32'h0, st & 32'h8);
		apb(1, ADDR_IRQS, 32'h7);
		apb(0, ADDR_IRQS, 0); chk("irqsClr", 32'h0, st & 32'h7);
		// break frame received, receiver switched off before reading
		peer.sendChar(8'h00, 1'b0);
		repeat (20) @(posedge clk);
		apb(1, ADDR_CTRL, CTL & ~32'h4);
		apb(0, ADDR_STAT, 0); chk("brkFlags", 32'h34, st & 32'h74);
		apb(0, ADDR_DATA, 0); chk("brkData", 32'h0, st & 32'h1FF);
		testDone();
	end
	// watchdog well beyond the few thousand cycles the sequence needs
	initial begin
		repeat (30000) @(posedge clk);
		nFail++;
		testDone();
	end
endmodule // tb
